// [verilog/pcsr_regs.sv]
// Purpose: coding sublayer control and status register bank on APB
// Assumes: status lines come from another clock domain
// Notes:   registers are 16 bits in the low half of the APB word
// What this block does
// - Writing one to the reset bit pulses a sublayer reset; bit reads 0.
// - The loopback bit enables loopback when one and holds until rewrite.
// - Control sits at 0x3000, reset in bit 15, loopback 14, resets to 0.
// - The alias at 0x38e6 shows the same two fields, lower bits zero.
// - The group nibble [15:12] is stripped before address compare.
// - Transmit low-power-idle received latches until software writes 0.
// - Receive low-power-idle received latches until software writes 0.
// - Transmit indication reads the live transmit idle state.
// - Receive indication reads the live receive idle state.
// - The fault flag latches until software writes 0 to it.
// - Link bit shows link up; writing 0 to it sets it.
// - Status sits at 0x38e7, resets to 0, reserved bits read 0.
`timescale 1ns/1ps
`default_nettype none
module pcsr_regs (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [17:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        tx_lpi_active,
  input  wire logic        rx_lpi_active,
  input  wire logic        fault_event,
  input  wire logic        link_up,
  input  wire logic [3:0]  tx_data,
  input  wire logic [3:0]  line_rx_data,
  output logic [3:0]       rx_data,
  output logic [3:0]       line_tx_data,
  output logic             sublayer_reset,
  output logic             sublayer_loop_enable,
  output logic             irq
);
  import pcsr_pkg::*;

  logic [4:0] raw_v;
  pcsr_sync_if sif ();
  assign raw_v    = {link_up, fault_event, rx_lpi_active, tx_lpi_active,
                     1'b0};
  assign sif.raw  = raw_v;
  pcsr_sync u_sync (
    .clk  (clk),
    .nrst (nrst),
    .sif  (sif)
  );

  logic tx_lpi_s;
  logic rx_lpi_s;
  logic fault_s;
  logic link_s;
  assign tx_lpi_s = sif.sync[1];
  assign rx_lpi_s = sif.sync[2];
  assign fault_s  = sif.sync[3];
  assign link_s   = sif.sync[4];

  // Strip group nibble, compare against the stripped index
  function automatic logic hit(input logic [15:0] idx,
                               input logic [15:0] cst);
    hit = (idx & PCSR_GROUP_MASK) == (cst & PCSR_GROUP_MASK);
  endfunction : hit

  logic [15:0] idx;
  logic        wr_acc;
  logic        rd_acc;
  logic        lo_en;
  logic        hi_en;
  logic [15:0] wd;
  assign idx    = paddr[17:2];
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !penable && !pwrite;
  assign lo_en  = pstrb[0];
  assign hi_en  = pstrb[1];
  assign wd     = pwdata[15:0];

  logic sel_ctrl;
  logic sel_stat;
  logic sel_ien;
  logic sel_ist;
  logic sel_iclr;
  logic mapped;
  assign sel_ctrl = hit(idx, PCSR_IDX_CTRL) || hit(idx, PCSR_IDX_CTRL_ALS);
  assign sel_stat = hit(idx, PCSR_IDX_STATUS);
  assign sel_ien  = hit(idx, PCSR_IDX_IRQ_EN);
  assign sel_ist  = hit(idx, PCSR_IDX_IRQ_STAT);
  assign sel_iclr = hit(idx, PCSR_IDX_IRQ_CLR);
  assign mapped   = sel_ctrl || sel_stat || sel_ien || sel_ist || sel_iclr;

  // Soft reset: one-cycle pulse, never stored so it reads zero
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sublayer_reset <= 1'b0;
    end else begin
      sublayer_reset <= wr_acc && sel_ctrl && hi_en
                        && wd[PCSR_RST_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sublayer_loop_enable <= PCSR_RESET_VAL[PCSR_LOOP_BIT];
    end else if (wr_acc && sel_ctrl && hi_en) begin
      sublayer_loop_enable <= wd[PCSR_LOOP_BIT];
    end
  end

  // Loop data around the line; line output idles low in loopback
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rx_data      <= 4'h0;
      line_tx_data <= 4'h0;
    end else begin
      rx_data      <= sublayer_loop_enable ? tx_data : line_rx_data;
      line_tx_data <= sublayer_loop_enable ? 4'h0 : tx_data;
    end
  end

  // Latched flags: a set in the same cycle as a clear wins
  logic txlpi_l;
  logic rxlpi_l;
  logic fault_l;
  logic link_l;
  logic st_wr;
  assign st_wr = wr_acc && sel_stat;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      txlpi_l <= 1'b0;
      rxlpi_l <= 1'b0;
      fault_l <= 1'b0;
    end else begin
      if (tx_lpi_s) begin
        txlpi_l <= 1'b1;
      end else if (st_wr && hi_en && !wd[PCSR_TXLPI_BIT]) begin
        txlpi_l <= 1'b0;
      end
      if (rx_lpi_s) begin
        rxlpi_l <= 1'b1;
      end else if (st_wr && hi_en && !wd[PCSR_RXLPI_BIT]) begin
        rxlpi_l <= 1'b0;
      end
      if (fault_s) begin
        fault_l <= 1'b1;
      end else if (st_wr && lo_en && !wd[PCSR_FAULT_BIT]) begin
        fault_l <= 1'b0;
      end
    end
  end

  // Link bit follows the line; a zero write forces it high, the next
  // change of the line level then takes over again
  logic link_q;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      link_l <= 1'b0;
      link_q <= 1'b0;
    end else begin
      link_q <= link_s;
      if (st_wr && lo_en && !wd[PCSR_LINK_BIT]) begin
        link_l <= 1'b1;
      end else if (link_s != link_q) begin
        link_l <= link_s;
      end
    end
  end

  logic [15:0] stat_v;
  always_comb begin
    stat_v                 = PCSR_RESET_VAL;
    stat_v[PCSR_TXLPI_BIT] = txlpi_l;
    stat_v[PCSR_RXLPI_BIT] = rxlpi_l;
    stat_v[PCSR_TXIND_BIT] = tx_lpi_s;
    stat_v[PCSR_RXIND_BIT] = rx_lpi_s;
    stat_v[PCSR_FAULT_BIT] = fault_l;
    stat_v[PCSR_LINK_BIT]  = link_l;
  end

  logic [15:0] ctrl_v;
  always_comb begin
    ctrl_v                = PCSR_RESET_VAL;
    ctrl_v[PCSR_LOOP_BIT] = sublayer_loop_enable;
  end

  // Interrupts: bit0 tx idle, bit1 rx idle, bit2 fault, bit3 link drop
  logic [3:0] irq_st;
  logic [3:0] irq_en;
  logic [3:0] ev;
  logic       link_fall;
  assign link_fall = link_q && !link_s;
  assign ev = {link_fall, fault_s, rx_lpi_s, tx_lpi_s};

  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq_en <= PCSR_IRQ_ZERO;
    end else if (wr_acc && sel_ien && lo_en) begin
      irq_en <= wd[PCSR_NIRQ-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq_st <= PCSR_IRQ_ZERO;
    end else if (wr_acc && sel_iclr && lo_en) begin
      irq_st <= (irq_st & ~wd[PCSR_NIRQ-1:0]) | ev;
    end else begin
      irq_st <= irq_st | ev;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_st & irq_en);
    end
  end

  // APB: read data captured in setup, ready in access phase
  logic [15:0] rd_v;
  always_comb begin
    rd_v = 16'h0000;
    if (sel_ctrl) begin
      rd_v = ctrl_v;
    end else if (sel_stat) begin
      rd_v = stat_v;
    end else if (sel_ien) begin
      rd_v = {12'h000, irq_en};
    end else if (sel_ist) begin
      rd_v = {12'h000, irq_st};
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      if (rd_acc) begin
        prdata <= {16'h0000, rd_v};
      end
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
    end
  end
endmodule : pcsr_regs
`default_nettype wire

// [shared/pcsr_pkg.sv]
// Purpose: constants for the coding sublayer control and status registers
// Assumes: APB slave, 32-bit data, 16-bit registers in the low half
// Notes:   byte address = 4 * register index
package pcsr_pkg;
  localparam logic [15:0] PCSR_GROUP_MASK   = 16'h0fff;
  localparam logic [15:0] PCSR_IDX_CTRL     = 16'h3000;
  localparam logic [15:0] PCSR_IDX_CTRL_ALS = 16'h38e6;
  localparam logic [15:0] PCSR_IDX_STATUS   = 16'h38e7;
  localparam logic [15:0] PCSR_IDX_IRQ_STAT = 16'h0f00;
  localparam logic [15:0] PCSR_IDX_IRQ_EN   = 16'h0f01;
  localparam logic [15:0] PCSR_IDX_IRQ_CLR  = 16'h0f02;
  localparam int          PCSR_ADDR_W       = 16;
  localparam int          PCSR_RST_BIT      = 15;
  localparam int          PCSR_LOOP_BIT     = 14;
  localparam int          PCSR_TXLPI_BIT    = 11;
  localparam int          PCSR_RXLPI_BIT    = 10;
  localparam int          PCSR_TXIND_BIT    = 9;
  localparam int          PCSR_RXIND_BIT    = 8;
  localparam int          PCSR_FAULT_BIT    = 7;
  localparam int          PCSR_LINK_BIT     = 2;
  localparam logic [15:0] PCSR_RESET_VAL    = 16'h0000;
  localparam int          PCSR_NIRQ         = 4;
  localparam logic [3:0]  PCSR_IRQ_ZERO     = 4'h0;
endpackage : pcsr_pkg

// [shared/pcsr_sync_if.sv]
// Purpose: carries raw sublayer status lines into the synchroniser
// Assumes: single clock
// Notes:   three status lines, one link level and a bit 0 tied low
`timescale 1ns/1ps
`default_nettype none
interface pcsr_sync_if;
  logic [4:0] raw;
  logic [4:0] sync;
  modport src (output raw, input sync);
  modport snk (input raw, output sync);
endinterface : pcsr_sync_if
`default_nettype wire

// [verilog/pcsr_sync.sv]
// Purpose: two-flop synchroniser for sublayer status inputs
// Assumes: inputs asynchronous to clk
// Notes:   first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module pcsr_sync (
  input  wire logic clk,
  input  wire logic nrst,
  pcsr_sync_if.snk  sif
);
  logic [4:0] stage1;
  logic [4:0] stage2;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      stage1 <= 5'h00;
      stage2 <= 5'h00;
    end else begin
      stage1 <= sif.raw;
      stage2 <= stage1;
    end
  end
  assign sif.sync = stage2;
endmodule : pcsr_sync
`default_nettype wire

// [tb/pcsr_regs_sva.sv]
// Purpose: bus and datapath checks on the sublayer register bank
// Assumes: zero-wait APB, one clock domain
// Notes:   group nibble paddr[17:14] is ignored, as the bank does
`timescale 1ns/1ps
`default_nettype none
module pcsr_regs_sva (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [3:0]  tx_data,
  input wire logic [3:0]  line_rx_data,
  input wire logic [3:0]  rx_data,
  input wire logic [3:0]  line_tx_data,
  input wire logic        sublayer_reset,
  input wire logic        sublayer_loop_enable
);
  logic [11:0] idx;
  logic        ctl;
  logic        map;
  logic        wctl;
  logic        wrst;
  assign idx  = paddr[13:2];
  assign ctl  = idx == 12'h000 || idx == 12'h8e6;
  assign map  = ctl || idx == 12'h8e7 || (idx >= 12'hf00 && idx <= 12'hf02);
  assign wctl = pready && pwrite && ctl && pstrb[1];
  assign wrst = wctl && pwdata[15];
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_unmapped_err: assert property (pready |-> pslverr == !map)
    else $error("error flag wrong");
  a_ctl_reserved: assert property (pready && !pwrite && ctl |->
    (prdata & 32'hffffbfff) == 32'h0) else $error("control bits wrong");
  a_stat_reserved: assert property (pready && !pwrite &&
    idx == 12'h8e7 |-> (prdata & 32'hfffff07b) == 32'h0)
    else $error("status reserved set");
  a_reset_pulse: assert property (wrst |=> sublayer_reset ##1
    !sublayer_reset) else $error("no reset pulse");
  a_reset_cause: assert property (sublayer_reset |-> $past(wrst))
    else $error("stray reset pulse");
  a_loop_write: assert property (wctl |=>
    sublayer_loop_enable == $past(pwdata[14])) else $error("loop not set");
  a_loop_hold: assert property (!wctl |=> $stable(sublayer_loop_enable))
    else $error("loop changed alone");
  a_loop_path: assert property (sublayer_loop_enable |=>
    rx_data == $past(tx_data) && line_tx_data == 4'h0)
    else $error("loop path wrong");
  a_line_path: assert property (!sublayer_loop_enable |=>
    rx_data == $past(line_rx_data) && line_tx_data == $past(tx_data))
    else $error("line path wrong");
endmodule : pcsr_regs_sva
bind pcsr_regs pcsr_regs_sva u_sva (.*);
`default_nettype wire

// [tb/pcs_control_status_regs_test.sv]
// Purpose: self-checking bench for the sublayer register bank
// Assumes: zero-wait APB, status inputs settle within six cycles
// Notes:   APB results are noted in a queue and judged at pready
`timescale 1ns/1ps
`default_nettype none
module pcs_control_status_regs_test;
  import pcsr_pkg::*;
  typedef struct packed {logic [31:0] d; logic e;} pcsr_note_t;
  logic        clk, nrst, psel, penable, pwrite, pready, pslverr, irq;
  logic        tx_lpi_active, rx_lpi_active, fault_event, link_up;
  logic        sublayer_reset, sublayer_loop_enable;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  pstrb, tx_data, line_rx_data, rx_data, line_tx_data;
  int          mismatches, samples_checked, cycles, pulses, p;
  pcsr_note_t  notes[$];
  pcsr_note_t  n;
  logic [15:0] tab [5] = '{PCSR_IDX_CTRL, PCSR_IDX_CTRL_ALS,
    PCSR_IDX_STATUS, PCSR_IDX_IRQ_STAT, PCSR_IDX_IRQ_EN};
  pcsr_regs dut (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic fail(input string m);
    mismatches++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask : fail
  task automatic cmp_bus(input pcsr_note_t x, input logic [31:0] d);
    samples_checked++;
    if (d !== x.d || pslverr !== x.e) fail($sformatf("bus %h", d));
  endtask : cmp_bus
  task automatic cmp_pin(input logic [3:0] g, input logic [3:0] w);
    samples_checked++;
    if (g !== w) fail($sformatf("pin %h want %h", g, w));
  endtask : cmp_pin
  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop
  // Results are judged at the access edge, before its updates land
  always @(posedge clk) begin
    cycles++;
    if (sublayer_reset === 1'b1) pulses++;
    if (psel && penable && pready === 1'b1) begin
      if (notes.size() == 0) fail("unexpected answer");
      else begin
        n = notes.pop_front();
        cmp_bus(n, pwrite ? n.d : prdata);
      end
    end
    if (cycles == 4000) begin
      fail("timeout");
      report_and_stop();
    end
  end
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [31:0] x, input logic e);
    @(posedge clk);
    notes.push_back({x, e});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {a, 2'b00};
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [15:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, 4'h0, x, 1'b0);
  endtask : rd
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'h3, 32'h0, 1'b0);
  endtask : wr
  task automatic data_chk(input logic lp);
    @(posedge clk);
    tx_data <= 4'($urandom);
    line_rx_data <= 4'($urandom);
    repeat (2) @(posedge clk);
    cmp_pin(rx_data, lp ? tx_data : line_rx_data);
    cmp_pin(line_tx_data, lp ? 4'h0 : tx_data);
  endtask : data_chk
  task automatic lines(input logic t, input logic x, input logic f);
    @(posedge clk);
    tx_lpi_active <= t;
    rx_lpi_active <= x;
    fault_event <= f;
    repeat (6) @(posedge clk);
  endtask : lines
  initial begin
    {nrst, psel, penable, pwrite, tx_lpi_active, rx_lpi_active} = 6'h0;
    {fault_event, link_up, paddr, pwdata, pstrb} = 56'h0;
    {tx_data, line_rx_data, mismatches, samples_checked, cycles} = 104'h0;
    pulses = 0;
    void'($urandom(32'h047fbdde));
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    foreach (tab[i]) rd(tab[i], 32'h0);
    $display("test reset values done");
    apb(1'b0, 16'h0123, 32'h0, 4'h0, 32'h0, 1'b1);
    apb(1'b1, 16'h0456, 32'hffff, 4'h3, 32'h0, 1'b1);
    wr(16'h0000, 32'h4000);
    rd(16'h58e6, 32'h4000);
    $display("test addressing done");
    for (int i = 0; i < 4; i++) begin
      r = $urandom;
      r[15] = i[0];
      p = pulses;
      wr(i[1] ? PCSR_IDX_CTRL_ALS : PCSR_IDX_CTRL, r);
      rd(PCSR_IDX_CTRL, r & 32'h4000);
      cmp_pin(4'(pulses - p), {3'h0, r[15]});
      data_chk(r[14]);
    end
    wr(PCSR_IDX_CTRL, 32'h4000);
    apb(1'b1, PCSR_IDX_CTRL, 32'h0, 4'h1, 32'h0, 1'b0);
    rd(PCSR_IDX_CTRL_ALS, 32'h4000);
    data_chk(1'b1);
    $display("test control done");
    wr(PCSR_IDX_IRQ_EN, 32'h1);
    lines(1'b1, 1'b1, 1'b1);
    rd(PCSR_IDX_STATUS, 32'h0f80);
    cmp_pin({3'h0, irq}, 4'h1);
    rd(PCSR_IDX_IRQ_STAT, 32'h7);
    lines(1'b0, 1'b0, 1'b0);
    wr(PCSR_IDX_STATUS, 32'hffff);
    rd(PCSR_IDX_STATUS, 32'h0c80);
    wr(PCSR_IDX_IRQ_EN, 32'h0);
    repeat (2) @(posedge clk);
    cmp_pin({3'h0, irq}, 4'h0);
    wr(PCSR_IDX_IRQ_EN, 32'h1);
    repeat (2) @(posedge clk);
    cmp_pin({3'h0, irq}, 4'h1);
    wr(PCSR_IDX_IRQ_CLR, 32'h1);
    repeat (2) @(posedge clk);
    cmp_pin({3'h0, irq}, 4'h0);
    wr(PCSR_IDX_STATUS, 32'h0);
    rd(PCSR_IDX_STATUS, 32'h4);
    link_up <= 1'b1;
    lines(1'b0, 1'b0, 1'b0);
    rd(PCSR_IDX_STATUS, 32'h4);
    link_up <= 1'b0;
    lines(1'b0, 1'b0, 1'b0);
    rd(PCSR_IDX_STATUS, 32'h0);
    rd(PCSR_IDX_IRQ_STAT, 32'he);
    $display("test status and interrupt done");
    repeat (2) @(posedge clk);
    report_and_stop();
  end
endmodule : pcs_control_status_regs_test
`default_nettype wire
